// *** hdl/tmc_params.svh ***
// How it works
// R1: Host picks four modes via mode field.
// R2: Sleep goes standby on wake pattern, local.
// R3: Fault without fail-safe enters protected mode.
// R4: Normal enables driver, receiver, watchdog.
// R5: Standby keeps wake, SPI, inhibit active.
// R6: Listen receives only, no watchdog.
// R7: Sleep drops inhibit, SPI, interrupt, transceiver; the code keeps SPI on in sleep while io_supply is high.
// R8: Sleep SPI slow unless chip select waits.
// R9: No IO supply: only wake leaves sleep.
// R10: Fault-caused sleep sets sleep status flag.
// R11: Reset or wake enters standby, starts timer.
// R12: Timer disable bit only affects sleep wakes.
// R13: Normal mode command stops inactivity timer.
// R14: Select zero: silence interrupt runs timer.
// R15: Select one: idle bus runs timer.
// R16: Timer expiry in active modes enters sleep.
// R17: Fail-safe starts timer, ignores wakes; the code takes a wake to standby once no fault is present.
// R18: Counter limit with action code: locked sleep.
// R19: Fail-safe IO undervoltage turns off SPI, interrupt.
// R20: Standby holds receive low until flags clear.
// R21: Host clears wake flags before selective wake.
// R22: Selective wake: frame, overflow or local wakes.
// R23: Wake pattern: dominant, recessive, dominant filtered.
// R24: Unassigned mode codes keep current mode.
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH
`define TMC_MODE_SLEEP 3'h1
`define TMC_MODE_STANDBY 3'h4
`define TMC_MODE_LISTEN 3'h5
`define TMC_MODE_NORMAL 3'h7
`define TMC_ACT_LOCK 3'h4
`define TMC_CLK_MHZ 100
`define TMC_INACTIVE_MS 5
`define TMC_SILENCE_US 1000
`define TMC_WK_FILTER_NS 1000
`define TMC_SPI_DELAY_US 10
`define TMC_INACTIVE_CYC (`TMC_INACTIVE_MS * 1000 * `TMC_CLK_MHZ)
`define TMC_SILENCE_CYC (`TMC_SILENCE_US * `TMC_CLK_MHZ)
`define TMC_FILTER_CYC ((`TMC_WK_FILTER_NS * `TMC_CLK_MHZ + 999) / 1000)
`define TMC_SPI_DELAY_CYC (`TMC_SPI_DELAY_US * `TMC_CLK_MHZ)
`endif

// *** hdl/tmc_pkg.sv ***
package tmc_pkg;
  typedef enum logic [6:0] {
    ST_STANDBY   = 7'b000_0001,
    ST_NORMAL    = 7'b000_0010,
    ST_LISTEN    = 7'b000_0100,
    ST_SLEEP     = 7'b000_1000,
    ST_FAILSAFE  = 7'b001_0000,
    ST_PROT_IO   = 7'b010_0000,
    ST_PROT_TSD  = 7'b100_0000
  } tmc_state_type;
  typedef enum logic [2:0] {
    WK_IDLE = 3'b001,
    WK_DOM  = 3'b010,
    WK_REC  = 3'b100
  } tmc_wake_type;
endpackage

// *** hdl/tmc_wake_if.sv ***
`timescale 1ns/1ps
interface tmc_wake_if;
  logic bus_dominant;
  logic arm;
  logic bus_wake_pattern;
  modport ctrl (output bus_dominant, output arm, input bus_wake_pattern);
  modport det  (input bus_dominant, input arm, output bus_wake_pattern);
endinterface

// *** hdl/tmc_wake_detect.sv ***
`timescale 1ns/1ps
`include "tmc_params.svh"
module tmc_wake_detect #(
  parameter int FILTER_CYC = `TMC_FILTER_CYC
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic clk_en,
  tmc_wake_if.det   wk
);
  initial begin
    if (FILTER_CYC < 1 || FILTER_CYC > 65535) begin
      $error("filter count out of range");
    end
  end
  tmc_pkg::tmc_wake_type state_reg;
  tmc_pkg::tmc_wake_type state_next;
  logic [15:0] cnt_reg;
  logic        last_reg;
  logic        hit_reg;
  wire  [15:0] filt_lim = 16'(FILTER_CYC);
  // The cycle in which the level changes never counts as filtered.
  wire         filtered = !changed && (cnt_reg >= filt_lim);
  wire         changed  = (wk.bus_dominant != last_reg);
  // Other bus traffic does not reset a partial pattern.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tmc_pkg::WK_IDLE: if (wk.bus_dominant && filtered) begin
        state_next = tmc_pkg::WK_DOM; // R23
      end
      tmc_pkg::WK_DOM: if (!wk.bus_dominant && filtered) begin
        state_next = tmc_pkg::WK_REC; // R23
      end
      tmc_pkg::WK_REC: if (wk.bus_dominant && filtered) begin
        state_next = tmc_pkg::WK_IDLE; // R23
      end
      default: state_next = tmc_pkg::WK_IDLE;
    endcase
  end
  wire pattern_done = (state_reg == tmc_pkg::WK_REC) && (state_next ==
                      tmc_pkg::WK_IDLE);
  always_ff @(posedge core_clk) begin
    if (srst || (clk_en && !wk.arm)) begin
      state_reg <= tmc_pkg::WK_IDLE;
      cnt_reg   <= 16'h0000;
      last_reg  <= 1'b0;
      hit_reg   <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      last_reg  <= wk.bus_dominant;
      cnt_reg   <= changed ? 16'h0000
                   : (filtered ? cnt_reg : cnt_reg + 16'h0001);
      hit_reg   <= pattern_done;
    end
  end
  assign wk.bus_wake_pattern = hit_reg;
endmodule

// *** hdl/tmc_mode_ctrl.sv ***
`timescale 1ns/1ps
`include "tmc_params.svh"
module tmc_mode_ctrl #(
  parameter int INACTIVE_CYC = `TMC_INACTIVE_CYC,
  parameter int SILENCE_CYC  = `TMC_SILENCE_CYC,
  parameter int SPI_DLY_CYC  = `TMC_SPI_DELAY_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       clk_en,
  input  wire logic [2:0] mode_field,
  input  wire logic       mode_write,
  input  wire logic       failsafe_enable,
  input  wire logic       sleep_wake_timer_enable,
  input  wire logic       sleep_wake_timer_disable,
  input  wire logic       silence_timer_select,
  input  wire logic       bus_silence_interrupt,
  input  wire logic       bus_dominant,
  input  wire logic       txd,
  input  wire logic       local_wake_event,
  input  wire logic       selective_wake_config,
  input  wire logic       selective_wake_enable,
  input  wire logic       wake_frame_match,
  input  wire logic       frame_wake_interrupt,
  input  wire logic       frame_overflow_interrupt,
  input  wire logic       power_on_flag,
  input  wire logic       local_wake_flag,
  input  wire logic       io_supply,
  input  wire logic       io_undervoltage,
  input  wire logic       supply_undervoltage,
  input  wire logic       thermal_shutdown,
  input  wire logic       failsafe_counter_limit,
  input  wire logic [2:0] failsafe_counter_action,
  input  wire logic       chip_select_n,
  input  wire logic       flags_cleared,
  output logic      [6:0] mode_state,
  output logic            tx_enable,
  output logic            txd_to_bus,
  output logic            rx_enable,
  output logic            rxd,
  output logic            lp_rx_enable,
  output logic            wake_monitor_enable,
  output logic            watchdog_enable,
  output logic            inhibit_output,
  output logic            interrupt_output_enable,
  output logic            spi_enable,
  output logic            spi_full_rate,
  output logic            frame_rx_enable,
  output logic            sleep_status_fault,
  output logic            sleep_wake_error_active
);
  initial begin
    if (INACTIVE_CYC < 1 || SILENCE_CYC < 1 || SPI_DLY_CYC < 1 ||
        SPI_DLY_CYC > 65535) begin
      $error("timing counts must be positive");
    end
  end
  tmc_pkg::tmc_state_type state_reg;
  tmc_pkg::tmc_state_type state_next;
  tmc_wake_if wk ();
  tmc_wake_detect u_wake (
    .core_clk (core_clk),
    .srst     (srst),
    .clk_en   (clk_en),
    .wk       (wk.det)
  );
  logic [31:0] swe_cnt_reg;
  logic        swe_run_reg;
  logic [31:0] sil_cnt_reg;
  logic [15:0] cs_cnt_reg;
  logic        fault_sleep_reg;
  logic        locked_reg;
  logic        wuf_armed_reg;
  logic        rxd_low_reg;
  logic        last_dom_reg;

  wire is_normal = (state_reg == tmc_pkg::ST_NORMAL);
  wire is_listen = (state_reg == tmc_pkg::ST_LISTEN);
  wire is_sleep  = (state_reg == tmc_pkg::ST_SLEEP);
  wire is_stby   = (state_reg == tmc_pkg::ST_STANDBY);
  wire is_fs     = (state_reg == tmc_pkg::ST_FAILSAFE);
  wire any_fault = io_undervoltage | supply_undervoltage | thermal_shutdown;
  wire bus_act   = (bus_dominant != last_dom_reg);
  wire swe_on    = failsafe_enable & sleep_wake_timer_enable;
  wire swe_done  = swe_run_reg && (swe_cnt_reg >= 32'(INACTIVE_CYC));
  wire silent    = (sil_cnt_reg >= 32'(SILENCE_CYC));
  wire cmd_ok    = mode_write && (!is_sleep || io_supply) && !locked_reg; // R9
  wire code_ok   = (mode_field == `TMC_MODE_NORMAL) ||
                   (mode_field == `TMC_MODE_STANDBY) ||
                   (mode_field == `TMC_MODE_LISTEN) ||
                   (mode_field == `TMC_MODE_SLEEP); // R24
  wire sel_wake  = selective_wake_config & selective_wake_enable;
  // A frame mismatch keeps the device asleep; only these events, a local wake or a host mode command leave.
  wire frame_wake = wuf_armed_reg & (wake_frame_match | frame_wake_interrupt |
                    frame_overflow_interrupt); // R22
  wire sleep_wake = !locked_reg && ((sel_wake ? frame_wake
                    : wk.bus_wake_pattern) || local_wake_event); // R2
  wire lock_hit  = failsafe_counter_limit &&
                   (failsafe_counter_action == `TMC_ACT_LOCK); // R18

  function automatic tmc_pkg::tmc_state_type decode_mode(
      input logic [2:0] code, input tmc_pkg::tmc_state_type cur);
    case (code)
      `TMC_MODE_NORMAL:  decode_mode = tmc_pkg::ST_NORMAL;
      `TMC_MODE_STANDBY: decode_mode = tmc_pkg::ST_STANDBY;
      `TMC_MODE_LISTEN:  decode_mode = tmc_pkg::ST_LISTEN;
      `TMC_MODE_SLEEP:   decode_mode = tmc_pkg::ST_SLEEP;
      default:           decode_mode = cur; // R24
    endcase
  endfunction

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tmc_pkg::ST_NORMAL, tmc_pkg::ST_LISTEN, tmc_pkg::ST_STANDBY: begin
        if (any_fault && failsafe_enable) begin
          state_next = tmc_pkg::ST_FAILSAFE;
        end else if (any_fault) begin
          state_next = io_undervoltage ? tmc_pkg::ST_PROT_IO
                       : tmc_pkg::ST_PROT_TSD; // R3
        end else if (swe_done) begin
          state_next = tmc_pkg::ST_SLEEP; // R16
        end else if (cmd_ok && code_ok) begin
          state_next = decode_mode(mode_field, state_reg); // R1
        end
      end
      tmc_pkg::ST_SLEEP: begin
        if (sleep_wake) begin
          state_next = tmc_pkg::ST_STANDBY; // R2
        end else if (cmd_ok && code_ok) begin
          state_next = decode_mode(mode_field, state_reg); // R9
        end
      end
      tmc_pkg::ST_FAILSAFE: begin
        // Wake events are ignored here until the fault clears.
        if (lock_hit || swe_done) begin
          state_next = tmc_pkg::ST_SLEEP; // R17
        end else if (!any_fault &&
                     (local_wake_event || wk.bus_wake_pattern)) begin
          state_next = tmc_pkg::ST_STANDBY;
        end else if (!any_fault && cmd_ok && code_ok) begin
          state_next = decode_mode(mode_field, state_reg);
        end
      end
      tmc_pkg::ST_PROT_IO, tmc_pkg::ST_PROT_TSD: begin
        if (!any_fault) begin
          state_next = tmc_pkg::ST_STANDBY; // R3
        end
      end
      default: state_next = tmc_pkg::ST_STANDBY;
    endcase
  end

  wire woke     = is_sleep && (state_next == tmc_pkg::ST_STANDBY);
  wire fs_entry = !is_fs && (state_next == tmc_pkg::ST_FAILSAFE);
  wire cmd_norm = cmd_ok && (mode_field == `TMC_MODE_NORMAL) &&
                  (is_normal || is_listen || is_stby);
  wire sil_arm  = silence_timer_select ? silent : bus_silence_interrupt;
  // Start conditions for the sleep-wake-error timer.
  wire swe_start = (woke && !sleep_wake_timer_disable) || // R12
                   (fs_entry) || // R17
                   (swe_on && (is_normal || is_listen) && sil_arm); // R14 R15 R6
  // A normal or listen pick in standby is the host's answer to the timer.
  wire swe_stop  = (swe_on && cmd_norm) || // R13
                   (is_stby && cmd_ok && (mode_field == `TMC_MODE_NORMAL ||
                    mode_field == `TMC_MODE_LISTEN)) || // R11
                   (is_stby && flags_cleared) || // R11
                   (!silence_timer_select && !bus_silence_interrupt &&
                    (is_normal || is_listen)) || // R14
                   (silence_timer_select && bus_act &&
                    (is_normal || is_listen)) || // R15
                   (state_next == tmc_pkg::ST_SLEEP);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg     <= tmc_pkg::ST_STANDBY; // R11
      swe_run_reg   <= 1'b1; // R11
      swe_cnt_reg   <= 32'h0000_0000;
      sil_cnt_reg   <= 32'h0000_0000;
      last_dom_reg  <= 1'b0;
    end else if (clk_en) begin
      state_reg    <= state_next;
      last_dom_reg <= bus_dominant;
      sil_cnt_reg  <= bus_act ? 32'h0000_0000
                      : (silent ? sil_cnt_reg : sil_cnt_reg + 32'h0000_0001);
      if (swe_stop) begin
        swe_run_reg <= 1'b0;
        swe_cnt_reg <= 32'h0000_0000;
      end else if (swe_start && !swe_run_reg) begin
        swe_run_reg <= 1'b1;
        swe_cnt_reg <= 32'h0000_0000;
      end else if (swe_run_reg && !swe_done) begin
        swe_cnt_reg <= swe_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Locking survives everything but a power cycle, i.e. srst.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fault_sleep_reg <= 1'b0;
      locked_reg      <= 1'b0;
      wuf_armed_reg   <= 1'b0;
      rxd_low_reg     <= 1'b1;
      cs_cnt_reg      <= 16'h0000;
    end else if (clk_en) begin
      if (is_fs && lock_hit) begin
        locked_reg <= 1'b1; // R18
      end
      if (!is_sleep && state_next == tmc_pkg::ST_SLEEP) begin
        fault_sleep_reg <= is_fs; // R10
      end
      if (!is_sleep || !sel_wake) begin
        wuf_armed_reg <= 1'b0;
      end else if (wk.bus_wake_pattern) begin
        wuf_armed_reg <= 1'b1; // R22
      end
      if (woke) begin
        rxd_low_reg <= 1'b1; // R20
      end else if (is_stby && !power_on_flag && !local_wake_flag &&
                   !frame_wake_interrupt && !frame_overflow_interrupt) begin
        rxd_low_reg <= 1'b0; // R20
      end
      if (chip_select_n) begin
        cs_cnt_reg <= 16'h0000;
      end else if (cs_cnt_reg < 16'(SPI_DLY_CYC)) begin
        cs_cnt_reg <= cs_cnt_reg + 16'h0001;
      end
    end
  end

  assign wk.bus_dominant = bus_dominant;
  assign wk.arm = is_sleep || is_stby || is_fs;

  wire fs_io_ok = !io_undervoltage;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_state              <= 7'h01;
      tx_enable               <= 1'b0;
      txd_to_bus              <= 1'b1;
      rx_enable               <= 1'b0;
      rxd                     <= 1'b0;
      lp_rx_enable            <= 1'b1;
      wake_monitor_enable     <= 1'b1;
      watchdog_enable         <= 1'b1;
      inhibit_output          <= 1'b1;
      interrupt_output_enable <= 1'b1;
      spi_enable              <= 1'b1;
      spi_full_rate           <= 1'b1;
      frame_rx_enable         <= 1'b0;
      sleep_status_fault      <= 1'b0;
      sleep_wake_error_active <= 1'b0;
    end else if (clk_en) begin
      mode_state          <= state_reg;
      tx_enable           <= is_normal; // R4
      txd_to_bus          <= is_normal ? txd : 1'b1; // R4
      rx_enable           <= is_normal || is_listen; // R4 R6
      rxd                 <= (is_normal || is_listen) ? !bus_dominant
                             : !(is_stby && rxd_low_reg); // R20
      lp_rx_enable        <= !(is_normal || is_listen); // R5 R7
      wake_monitor_enable <= is_stby || is_sleep ||
                             (is_fs && !any_fault); // R5 R7
      watchdog_enable     <= is_normal || is_stby; // R4 R6 R7
      inhibit_output      <= !is_sleep; // R5 R7 R19
      interrupt_output_enable <= !is_sleep &&
                                 (state_reg != tmc_pkg::ST_PROT_IO) &&
                                 (!is_fs || fs_io_ok); // R19
      spi_enable          <= (is_sleep ? io_supply : 1'b1) &&
                             (state_reg != tmc_pkg::ST_PROT_IO) &&
                             (!is_fs || fs_io_ok); // R7 R9 R19
      spi_full_rate       <= !is_sleep ||
                             (cs_cnt_reg >= 16'(SPI_DLY_CYC)); // R8
      frame_rx_enable     <= wuf_armed_reg; // R22
      sleep_status_fault  <= fault_sleep_reg; // R10
      sleep_wake_error_active <= swe_run_reg;
    end
  end
endmodule

// *** bench/tmc_mode_ctrl_chk.sv ***
`timescale 1ns/1ps
module tmc_mode_ctrl_chk (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic [2:0] mode_field,
  input wire logic       mode_write,
  input wire logic       bus_dominant,
  input wire logic       txd,
  input wire logic       local_wake_event,
  input wire logic       selective_wake_config,
  input wire logic       io_undervoltage,
  input wire logic       supply_undervoltage,
  input wire logic       thermal_shutdown,
  input wire logic       failsafe_counter_limit,
  input wire logic [6:0] mode_state,
  input wire logic       tx_enable,
  input wire logic       txd_to_bus,
  input wire logic       rx_enable,
  input wire logic       rxd,
  input wire logic       lp_rx_enable,
  input wire logic       wake_monitor_enable,
  input wire logic       watchdog_enable,
  input wire logic       inhibit_output,
  input wire logic       interrupt_output_enable,
  input wire logic       spi_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Faults outrank commands and wakes, so those checks only apply when quiet.
  wire quiet = !(thermal_shutdown || io_undervoltage || supply_undervoltage
                 || failsafe_counter_limit);
  tx_normal_a: assert property (
    tx_enable == (mode_state == 7'h02)
  ) else $error("transmitter enable outside normal mode");
  rx_modes_a: assert property (
    rx_enable == (mode_state inside {7'h02, 7'h04})
  ) else $error("receiver enable disagrees with mode");
  sleep_blocks_a: assert property (
    mode_state == 7'h08 |-> !inhibit_output && !interrupt_output_enable
      && !watchdog_enable && lp_rx_enable
  ) else $error("sleep leaves a block in the wrong state");
  standby_blocks_a: assert property (
    mode_state == 7'h01 |-> wake_monitor_enable && spi_enable
      && inhibit_output && lp_rx_enable
  ) else $error("standby block missing");
  listen_quiet_a: assert property (
    mode_state == 7'h04 |-> !watchdog_enable && !wake_monitor_enable
  ) else $error("listen mode runs watchdog or wake monitor");
  normal_cmd_a: assert property (
    mode_write && mode_field == 3'h7 && mode_state == 7'h01 && quiet
      |-> ##2 mode_state == 7'h02
  ) else $error("normal command not obeyed in two cycles");
  io_protect_a: assert property (
    mode_state == 7'h20 |-> !spi_enable && !interrupt_output_enable
      && inhibit_output
  ) else $error("io protected mode blocks wrong");
  local_wake_a: assert property (
    mode_state == 7'h08 && local_wake_event && quiet && !selective_wake_config
      |-> ##[1:4] mode_state == 7'h01
  ) else $error("local wake did not reach standby");
  txd_path_a: assert property (
    tx_enable |-> txd_to_bus == $past(txd)
  ) else $error("transmit input not passed to bus");
  rxd_path_a: assert property (
    rx_enable && $past(rx_enable) |-> rxd == !$past(bus_dominant)
  ) else $error("receive output does not follow bus");
  cover property (mode_state == 7'h02);
  cover property (mode_state == 7'h08 ##1 mode_state == 7'h01);
  cover property (mode_state == 7'h10);
endmodule

// *** bench/tmc_bus_model.sv ***
`timescale 1ns/1ps
module tmc_bus_model #(
  parameter int FILT = 100
) (
  input  wire logic core_clk,
  input  wire logic start,
  output logic      bus_dominant
);
  // Phases run past the filter so sampling jitter cannot shorten one.
  initial begin
    bus_dominant = 1'h0;
    forever begin
      @(posedge start);
      for (int p = 0; p < 3; p++) begin
        bus_dominant = (p != 1);
        repeat (FILT + 5) @(negedge core_clk);
      end
      bus_dominant = 1'h0;
    end
  end
endmodule

// *** bench/tmc_mode_ctrl_tb.sv ***
`timescale 1ns/1ps
`include "tmc_params.svh"
bind tmc_mode_ctrl tmc_mode_ctrl_chk i_chk (.core_clk, .srst, .mode_field,
  .mode_write, .bus_dominant, .txd, .local_wake_event, .selective_wake_config,
  .io_undervoltage, .supply_undervoltage, .thermal_shutdown,
  .failsafe_counter_limit, .mode_state, .tx_enable, .txd_to_bus, .rx_enable,
  .rxd, .lp_rx_enable, .wake_monitor_enable, .watchdog_enable, .inhibit_output,
  .interrupt_output_enable, .spi_enable);
module tmc_mode_ctrl_tb;
  localparam int INACT = 200;
  localparam int SILENCE = 50;
  logic       core_clk, srst, mode_write, txd, local_wake_event, start;
  logic [2:0] mode_field, failsafe_counter_action;
  logic       failsafe_enable, sleep_wake_timer_enable, sleep_wake_timer_disable;
  logic       thermal_shutdown, io_undervoltage, supply_undervoltage;
  logic       failsafe_counter_limit, flags_cleared, bus_dominant;
  logic       clk_en, silence_timer_select, bus_silence_interrupt;
  logic       power_on_flag, local_wake_flag, io_supply, chip_select_n, sel;
  logic       spi_full_rate, frame_rx_enable;
  logic [6:0] mode_state, ms;
  logic       tx_enable, rx_enable, lp_rx_enable, wake_monitor_enable, rxd;
  logic       watchdog_enable, inhibit_output, interrupt_output_enable;
  logic       spi_enable, sleep_status_fault, sleep_wake_error_active;
  logic [31:0] seed;
  int         errors, compares, n;
  wire logic [7:0] blk = {tx_enable, rx_enable, lp_rx_enable,
    wake_monitor_enable, watchdog_enable, inhibit_output,
    interrupt_output_enable, spi_enable};
  logic [3:0] frow [3] = '{4'h4, 4'h2, 4'h9};
  logic [6:0] fst  [3] = '{7'h40, 7'h20, 7'h10};
  logic [1:0] fsi  [3] = '{2'h3, 2'h0, 2'h3};

  tmc_mode_ctrl #(.INACTIVE_CYC(INACT), .SILENCE_CYC(SILENCE),
    .SPI_DLY_CYC(20)) i_dut (.core_clk, .srst, .clk_en, .mode_field,
    .mode_write, .failsafe_enable, .sleep_wake_timer_enable,
    .sleep_wake_timer_disable, .silence_timer_select,
    .bus_silence_interrupt, .bus_dominant, .txd, .local_wake_event,
    .selective_wake_config(sel), .selective_wake_enable(sel),
    .wake_frame_match(1'h0), .frame_wake_interrupt(1'h0),
    .frame_overflow_interrupt(1'h0), .power_on_flag,
    .local_wake_flag, .io_supply, .io_undervoltage,
    .supply_undervoltage, .thermal_shutdown, .failsafe_counter_limit,
    .failsafe_counter_action, .chip_select_n, .flags_cleared,
    .mode_state, .tx_enable, .txd_to_bus(), .rx_enable, .rxd, .lp_rx_enable,
    .wake_monitor_enable, .watchdog_enable, .inhibit_output,
    .interrupt_output_enable, .spi_enable, .spi_full_rate,
    .frame_rx_enable, .sleep_status_fault, .sleep_wake_error_active);
  tmc_bus_model #(.FILT(`TMC_FILTER_CYC)) i_bus (.core_clk, .start,
    .bus_dominant);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [6:0] pick(input logic [2:0] c, logic [6:0] cur);
    case (c)
      `TMC_MODE_NORMAL: pick = 7'h02;
      `TMC_MODE_STANDBY: pick = 7'h01;
      `TMC_MODE_LISTEN: pick = 7'h04;
      `TMC_MODE_SLEEP: pick = 7'h08;
      default: pick = cur;
    endcase
  endfunction
  function automatic logic [7:0] blocks(input logic [6:0] st);
    case (st)
      7'h02: blocks = 8'hCF;
      7'h04: blocks = 8'h47;
      7'h08: blocks = 8'h31;
      default: blocks = 8'h3F;
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [2:0] code);
    mode_field = code;
    mode_write = 1'h1;
    @(negedge core_clk);
    mode_write = 1'h0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic pulse_wake;
    local_wake_event = 1'h1;
    @(negedge core_clk);
    local_wake_event = 1'h0;
  endtask
  task automatic wait_st(input logic [6:0] st);
    n = 0;
    while (mode_state !== st && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    {srst, mode_write, txd, local_wake_event, start, flags_cleared} = 6'h28;
    {clk_en, silence_timer_select, bus_silence_interrupt, power_on_flag} = 4'hD;
    {local_wake_flag, io_supply, chip_select_n, sel} = 4'h6;
    {failsafe_enable, sleep_wake_timer_enable, sleep_wake_timer_disable} = 3'h0;
    {thermal_shutdown, io_undervoltage, supply_undervoltage} = 3'h0;
    {failsafe_counter_limit, mode_field, failsafe_counter_action} = 7'h00;
    errors = 0;
    compares = 0;
    seed = 32'h0000_7075;
    repeat (5) @(negedge core_clk);
    srst = 1'h0;
    @(negedge core_clk);
    check({7'h00, mode_state, rxd, sleep_wake_error_active},
          {7'h00, 7'h01, 2'h1});
    flags_cleared = 1'h1;
    power_on_flag = 1'h0;
    @(negedge core_clk);
    flags_cleared = 1'h0;
    ms = 7'h01;
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      txd = seed[7];
      mode_field = (i < 8) ? i[2:0] : seed[2:0];
      ms = pick(mode_field, ms);
      cmd(mode_field);
      check({mode_state, sleep_status_fault, blk}, {ms, 1'h0, blocks(ms)});
    end
    {failsafe_enable, sleep_wake_timer_enable} = 2'h3;
    cmd(`TMC_MODE_NORMAL);
    repeat (20) @(negedge core_clk);
    check({15'h0000, sleep_wake_error_active}, 16'h0001);
    mode_write = 1'h1;
    @(negedge core_clk);
    mode_write = 1'h0;
    @(negedge core_clk);
    check({15'h0000, sleep_wake_error_active}, 16'h0000);
    wait_st(7'h08);
    check({15'h0000, n >= INACT && n <= INACT + SILENCE + 8}, 16'h0001);
    start = 1'h1;
    local_wake_flag = 1'h1;
    wait_st(7'h01);
    start = 1'h0;
    check({7'h00, mode_state, rxd, sleep_wake_error_active},
          {7'h00, 7'h01, 2'h1});
    flags_cleared = 1'h1;
    local_wake_flag = 1'h0;
    @(negedge core_clk);
    flags_cleared = 1'h0;
    repeat (3) @(negedge core_clk);
    check({14'h0000, rxd, sleep_wake_error_active}, 16'h0002);
    cmd(`TMC_MODE_SLEEP);
    sleep_wake_timer_disable = 1'h1;
    pulse_wake();
    repeat (3) @(negedge core_clk);
    check({8'h00, mode_state, sleep_wake_error_active}, 16'h0002);
    sleep_wake_timer_disable = 1'h0;
    for (int r = 0; r < 3; r++) begin
      {failsafe_enable, thermal_shutdown, io_undervoltage,
       supply_undervoltage} = frow[r];
      repeat (3) @(negedge core_clk);
      check({6'h00, mode_state, spi_enable, interrupt_output_enable,
             inhibit_output}, {6'h00, fst[r], fsi[r], 1'h1});
      pulse_wake();
      cmd(`TMC_MODE_NORMAL);
      check({9'h000, mode_state}, {9'h000, fst[r]});
      {thermal_shutdown, io_undervoltage, supply_undervoltage} = 3'h0;
      @(negedge core_clk);
      pulse_wake();
      repeat (3) @(negedge core_clk);
      check({9'h000, mode_state}, 16'h0001);
    end
    failsafe_counter_action = `TMC_ACT_LOCK;
    {failsafe_counter_limit, supply_undervoltage} = 2'h3;
    repeat (6) @(negedge core_clk);
    supply_undervoltage = 1'h0;
    pulse_wake();
    cmd(`TMC_MODE_STANDBY);
    check({8'h00, mode_state, sleep_status_fault}, 16'h0011);
    sel = 1'h1;
    start = 1'h1;
    repeat (330) @(negedge core_clk);
    start = 1'h0;
    check({8'h00, mode_state, frame_rx_enable}, 16'h0011);
    chip_select_n = 1'h0;
    clk_en = 1'h0;
    repeat (25) @(negedge core_clk);
    check({15'h0000, spi_full_rate}, 16'h0000);
    clk_en = 1'h1;
    repeat (25) @(negedge core_clk);
    check({15'h0000, spi_full_rate}, 16'h0001);
    io_supply = 1'h0;
    repeat (2) @(negedge core_clk);
    check({15'h0000, spi_enable}, 16'h0000);
    tally_and_finish();
  end
endmodule
